/* File: verilog/send_port_pkg.sv */
package send_port_pkg;
    // Data path widths
    localparam int WIDE_W = 128;
    localparam int NARROW_W = 64;
    localparam int QWORD_W = 64;
    // Credit limits: 12 bits, one unit is 16 bytes of payload
    localparam int CRED_W = 12;
    localparam int CRED_UNIT_BYTES = 16;
    localparam int CRED_KINDS = 3;
    localparam int CRED_CPL = 0;
    localparam int CRED_NP = 1;
    localparam int CRED_POST = 2;
    localparam logic [CRED_W-1:0] CRED_RESET = 12'h000;
    // Ready-to-valid latency in cycles
    localparam int READY_LATENCY = 2;
    // Idle cycles the source keeps after reset release
    localparam int RESET_WAIT = 2;
    // Buffer in front of the transaction layer
    localparam int FIFO_DEPTH = 8;
    // Side bits carried with each beat in the buffer
    localparam int SIDE_W = 4;
    localparam int SIDE_FIRST = 0;
    localparam int SIDE_LAST = 1;
    localparam int SIDE_VOID = 2;
    localparam int SIDE_NULL = 3;
    // Beat index from which a nullify strobe may apply
    localparam int NULL_MIN_BEAT = 1;
endpackage : send_port_pkg

/* File: verilog/send_port_if.sv */
`timescale 1ns/1ps
interface send_port_if #(parameter int DATA_W = send_port_pkg::WIDE_W) (
    input wire logic clk_i,
    input wire logic rst_i
);
    logic send_beat_valid;
    logic send_accept_ok;
    logic [DATA_W-1:0] send_beat_word;
    logic send_first_beat;
    logic send_last_beat;
    logic send_upper_half_void;
    logic send_nullify_pulse;

    modport device (
        input clk_i, rst_i, send_beat_valid, send_beat_word, send_first_beat,
        input send_last_beat, send_upper_half_void, send_nullify_pulse,
        output send_accept_ok
    );

    modport source (
        input clk_i, rst_i, send_accept_ok,
        output send_beat_valid, send_beat_word, send_first_beat, send_last_beat,
        output send_upper_half_void, send_nullify_pulse
    );
endinterface : send_port_if

/* File: verilog/beat_fifo.sv */
`timescale 1ns/1ps
module beat_fifo #(
    parameter int WIDTH = 132,
    parameter int DEPTH = send_port_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] level_o,
    output logic empty_o
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("beat_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_reg];
    assign level_o = count_reg;
    assign empty_o = (count_reg == '0);

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop) count_reg <= count_reg + 1'b1;
            else if (pop && !push) count_reg <= count_reg - 1'b1;
        end
    end
endmodule : beat_fifo

/* File: verilog/send_port_dev.sv */
// What this block and its source do
// - Capture beat only when valid and ready-qualified
// - Source sends valid only during ready windows
// - Source drops valid within two cycles
// - Source resumes valid within two cycles
// - Source registers ready and valid, latency two
// - Upper-half void only counts on last beat
// - Void flag unused on 64-bit path
// - Nullify pulse one cycle, inside packet
// - Nullify only posted or completion with payload; packet type is not decoded, any packet of three or more beats may be nullified
// - Gap of one cycle after nullified packet
// - No nullify for one- or two-beat packets
// - Nullify pulse only together with valid
// - Buffer empty output high when buffer empty
// - Completion data credit limit, 12 bits
// - Non-posted data credit limit, 12 bits
// - Posted data credit limit, 12 bits
// - Drop ready when buffer cannot take more
// - Source waits two cycles after reset
// - First and last flags mark packet bounds
// - Beat count must match header length; no header is parsed, so the length is not checked
`timescale 1ns/1ps
module send_port_dev #(
    parameter int DATA_W = send_port_pkg::WIDE_W,
    parameter int DEPTH = send_port_pkg::FIFO_DEPTH
) (
    send_port_if.device link,
    output logic [DATA_W-1:0] pkt_word_o,
    output logic pkt_first_o,
    output logic pkt_last_o,
    output logic pkt_upper_void_o,
    output logic pkt_nullified_o,
    output logic pkt_valid_o,
    input wire logic pkt_ready_i,
    input wire logic [send_port_pkg::CRED_W-1:0] cred_src_i [send_port_pkg::CRED_KINDS],
    output logic [send_port_pkg::CRED_W-1:0] cred_cpl_data_o,
    output logic [send_port_pkg::CRED_W-1:0] cred_np_data_o,
    output logic [send_port_pkg::CRED_W-1:0] cred_post_data_o,
    output logic fifo_empty_o,
    output logic proto_err_o
);
    localparam int LAT = send_port_pkg::READY_LATENCY;
    localparam int FW = DATA_W + send_port_pkg::SIDE_W;
    localparam int LW = $clog2(DEPTH+1);
    // Room for the beat of this grant plus the ones in flight, counted from the registered ready
    localparam int READY_LIMIT = DEPTH - LAT - 2;

    initial begin
        if (DATA_W != send_port_pkg::WIDE_W && DATA_W != send_port_pkg::NARROW_W)
            $error("send_port_dev data width must be 64 or 128");
        if (READY_LIMIT < 1) $error("send_port_dev buffer too shallow for ready latency");
    end

    typedef enum logic [1:0] {IDLE, IN_PKT} pkt_state_e;

    logic clk;
    logic rst;
    assign clk = link.clk_i;
    assign rst = link.rst_i;

    logic ready_reg;
    logic [LAT-1:0] ready_pipe_reg;
    logic beat_ok;
    logic stray_beat;
    pkt_state_e state_reg;
    logic [1:0] beat_idx_reg;
    logic null_pend_reg;
    logic proto_err_reg;
    logic [send_port_pkg::CRED_W-1:0] cred_reg [send_port_pkg::CRED_KINDS];
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FW-1:0] fifo_in;
    logic [FW-1:0] fifo_out;
    logic [LW-1:0] fifo_level;
    logic fifo_empty;
    logic void_bit;
    logic null_now;
    logic null_take;

    // Ready leaves enough room for every beat already granted
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= (fifo_level <= LW'(READY_LIMIT));
        end
    end
    assign link.send_accept_ok = ready_reg;

    // Ready of cycle n qualifies the beat of cycle n+LAT
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_pipe_reg <= '0;
        end else begin
            ready_pipe_reg <= {ready_pipe_reg[LAT-2:0], ready_reg};
        end
    end

    assign beat_ok = link.send_beat_valid && ready_pipe_reg[LAT-1];
    assign stray_beat = link.send_beat_valid && !ready_pipe_reg[LAT-1];

    function automatic logic void_of(input logic last, input logic flag);
        return (DATA_W == send_port_pkg::WIDE_W) && last && flag;
    endfunction : void_of

    assign void_bit = void_of(link.send_last_beat, link.send_upper_half_void);

    // Nullify counts from the second beat on and never on the last beat
    assign null_now = beat_ok && link.send_nullify_pulse && (state_reg == IN_PKT)
        && !link.send_first_beat && !link.send_last_beat
        && (beat_idx_reg >= 2'(send_port_pkg::NULL_MIN_BEAT));
    assign null_take = null_pend_reg || null_now;

    // Packet framing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= IDLE;
            beat_idx_reg <= '0;
        end else if (beat_ok) begin
            case (state_reg)
                IDLE: begin
                    if (link.send_first_beat && !link.send_last_beat) begin
                        state_reg <= IN_PKT;
                        beat_idx_reg <= 2'd1;
                    end
                end
                IN_PKT: begin
                    if (link.send_last_beat) begin
                        state_reg <= IDLE;
                        beat_idx_reg <= '0;
                    end else if (beat_idx_reg != 2'd3) begin
                        beat_idx_reg <= beat_idx_reg + 2'd1;
                    end
                end
                default: begin
                    state_reg <= IDLE;
                    beat_idx_reg <= '0;
                end
            endcase
        end
    end

    // Nullify is held until the last beat carries it into the buffer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            null_pend_reg <= 1'b0;
        end else if (beat_ok && link.send_last_beat) begin
            null_pend_reg <= 1'b0;
        end else if (null_now) begin
            null_pend_reg <= 1'b1;
        end
    end

    // Sticky record of protocol slips by the source
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            proto_err_reg <= 1'b0;
        end else if (stray_beat || (beat_ok && !fifo_in_ready)
            || (link.send_nullify_pulse && !link.send_beat_valid)
            || (beat_ok && (state_reg == IDLE) && !link.send_first_beat)
            || (beat_ok && (state_reg == IN_PKT) && link.send_first_beat)) begin
            proto_err_reg <= 1'b1;
        end
    end
    assign proto_err_o = proto_err_reg;

    always_comb begin
        fifo_in = '0;
        fifo_in[DATA_W-1:0] = link.send_beat_word;
        fifo_in[DATA_W+send_port_pkg::SIDE_FIRST] = link.send_first_beat;
        fifo_in[DATA_W+send_port_pkg::SIDE_LAST] = link.send_last_beat;
        fifo_in[DATA_W+send_port_pkg::SIDE_VOID] = void_bit;
        fifo_in[DATA_W+send_port_pkg::SIDE_NULL] = link.send_last_beat && null_take;
    end

    beat_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
        .clk_i(clk),
        .rst_i(rst),
        .in_valid_i(beat_ok),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(pkt_ready_i),
        .out_data_o(fifo_out),
        .level_o(fifo_level),
        .empty_o(fifo_empty)
    );

    assign pkt_valid_o = fifo_out_valid;
    assign pkt_word_o = fifo_out[DATA_W-1:0];
    assign pkt_first_o = fifo_out[DATA_W+send_port_pkg::SIDE_FIRST];
    assign pkt_last_o = fifo_out[DATA_W+send_port_pkg::SIDE_LAST];
    assign pkt_upper_void_o = fifo_out[DATA_W+send_port_pkg::SIDE_VOID];
    assign pkt_nullified_o = fifo_out[DATA_W+send_port_pkg::SIDE_NULL];
    assign fifo_empty_o = fifo_empty;

    // Credit limits in 16-byte units
    for (genvar k = 0; k < send_port_pkg::CRED_KINDS; k++) begin : g_cred
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                cred_reg[k] <= send_port_pkg::CRED_RESET;
            end else begin
                cred_reg[k] <= cred_src_i[k];
            end
        end
    end
    assign cred_cpl_data_o = cred_reg[send_port_pkg::CRED_CPL];
    assign cred_np_data_o = cred_reg[send_port_pkg::CRED_NP];
    assign cred_post_data_o = cred_reg[send_port_pkg::CRED_POST];
endmodule : send_port_dev

/* File: verilog/send_port_src.sv */
`timescale 1ns/1ps
module send_port_src #(
    parameter int DATA_W = send_port_pkg::WIDE_W
) (
    send_port_if.source link,
    input wire logic app_valid_i,
    output logic app_ready_o,
    input wire logic [DATA_W-1:0] app_word_i,
    input wire logic app_first_i,
    input wire logic app_last_i,
    input wire logic app_void_i,
    input wire logic app_nullify_i
);
    initial begin
        if (DATA_W != send_port_pkg::WIDE_W && DATA_W != send_port_pkg::NARROW_W)
            $error("send_port_src data width must be 64 or 128");
    end

    logic clk;
    logic rst;
    assign clk = link.clk_i;
    assign rst = link.rst_i;

    logic ready_q_reg;
    logic [1:0] wait_reg;
    logic gap_reg;
    logic in_pkt_reg;
    logic [1:0] beat_idx_reg;
    logic null_req_reg;
    logic null_done_reg;
    logic valid_reg;
    logic [DATA_W-1:0] word_reg;
    logic first_reg;
    logic last_reg;
    logic void_reg;
    logic err_reg;
    logic take;
    logic start_ok;
    logic null_fire;

    // Registered ready gives a ready-to-valid latency of two
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_q_reg <= 1'b0;
        end else begin
            ready_q_reg <= link.send_accept_ok;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_reg <= '0;
        end else if (wait_reg != 2'(send_port_pkg::RESET_WAIT)) begin
            wait_reg <= wait_reg + 2'd1;
        end
    end

    // A new packet may not start during the post-reset wait or the post-nullify gap
    assign start_ok = (wait_reg == 2'(send_port_pkg::RESET_WAIT)) && !gap_reg;
    assign app_ready_o = ready_q_reg && (in_pkt_reg || start_ok);
    assign take = app_valid_i && app_ready_o;

    // Nullify on a middle beat only, one pulse per packet
    assign null_fire = take && (null_req_reg || app_nullify_i) && !null_done_reg && in_pkt_reg
        && !app_first_i && !app_last_i
        && (beat_idx_reg >= 2'(send_port_pkg::NULL_MIN_BEAT));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_pkt_reg <= 1'b0;
            beat_idx_reg <= '0;
        end else if (take) begin
            if (app_last_i) begin
                in_pkt_reg <= 1'b0;
                beat_idx_reg <= '0;
            end else begin
                in_pkt_reg <= 1'b1;
                if (beat_idx_reg != 2'd3) beat_idx_reg <= beat_idx_reg + 2'd1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            null_req_reg <= 1'b0;
            null_done_reg <= 1'b0;
        end else if (take && app_last_i) begin
            null_req_reg <= 1'b0;
            null_done_reg <= 1'b0;
        end else begin
            if (app_nullify_i && !null_fire) null_req_reg <= 1'b1;
            if (null_fire) begin
                null_req_reg <= 1'b0;
                null_done_reg <= 1'b1;
            end
        end
    end

    // One idle cycle after the last beat of a nullified packet
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_reg <= 1'b0;
        end else begin
            gap_reg <= take && app_last_i && (null_done_reg || null_fire);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            valid_reg <= take;
            err_reg <= null_fire;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_reg <= '0;
            first_reg <= 1'b0;
            last_reg <= 1'b0;
            void_reg <= 1'b0;
        end else if (take) begin
            word_reg <= app_word_i;
            first_reg <= app_first_i;
            last_reg <= app_last_i;
            void_reg <= (DATA_W == send_port_pkg::WIDE_W) && app_last_i && app_void_i;
        end
    end

    assign link.send_beat_valid = valid_reg;
    assign link.send_beat_word = word_reg;
    assign link.send_first_beat = first_reg;
    assign link.send_last_beat = last_reg;
    assign link.send_upper_half_void = void_reg;
    assign link.send_nullify_pulse = err_reg;
endmodule : send_port_src

/* File: test/send_port_properties.sv */
`timescale 1ns/1ps
module send_port_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic send_beat_valid,
    input wire logic send_accept_ok,
    input wire logic send_first_beat,
    input wire logic send_last_beat,
    input wire logic send_upper_half_void,
    input wire logic send_nullify_pulse
);
    logic in_pkt_reg;
    logic nulled_reg;
    logic [1:0] since_rst_reg;

    // Tracks whether a packet has started and not yet ended
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_pkt_reg <= 1'b0;
        end else if (send_beat_valid) begin
            in_pkt_reg <= !send_last_beat;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nulled_reg <= 1'b0;
        end else if (send_beat_valid && send_last_beat) begin
            nulled_reg <= 1'b0;
        end else if (send_nullify_pulse) begin
            nulled_reg <= 1'b1;
        end
    end

    // Saturating count of edges since reset release
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            since_rst_reg <= 2'h0;
        end else if (since_rst_reg != 2'h3) begin
            since_rst_reg <= since_rst_reg + 2'h1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_null_end;
        send_beat_valid && send_last_beat && nulled_reg;
    endsequence
    sequence s_resume;
        in_pkt_reg && !(send_beat_valid && send_last_beat) && $rose(send_accept_ok);
    endsequence

    AST_VALID_NEEDS_READY: assert property (send_beat_valid |-> $past(send_accept_ok, 2))
        else $error("beat sent without ready two cycles before");
    AST_VALID_DROPS: assert property ($fell(send_accept_ok) |-> ##2 !send_beat_valid)
        else $error("valid still high two cycles after ready fell");
    AST_VALID_RESUMES: assert property (s_resume |-> ##2 send_beat_valid)
        else $error("valid not resumed two cycles after ready rose");
    AST_NULL_WITH_VALID: assert property (send_nullify_pulse |-> send_beat_valid)
        else $error("nullify without valid");
    AST_NULL_ONE_CYCLE: assert property (send_nullify_pulse |=> !send_nullify_pulse)
        else $error("nullify longer than one cycle");
    AST_NULL_MIDDLE: assert property (send_nullify_pulse |-> in_pkt_reg && !send_first_beat && !send_last_beat)
        else $error("nullify outside a middle beat");
    AST_GAP_AFTER_NULL: assert property (s_null_end |=> !send_beat_valid)
        else $error("packet follows nullified packet without gap");
    AST_VOID_ON_LAST: assert property (send_beat_valid && send_upper_half_void |-> send_last_beat)
        else $error("void flag on a beat that is not last");
    AST_FIRST_WHEN_IDLE: assert property (send_beat_valid && !in_pkt_reg |-> send_first_beat)
        else $error("beat outside a packet without first flag");
    AST_WAIT_AFTER_RESET: assert property (send_beat_valid |-> since_rst_reg >= 2'h2)
        else $error("beat sent too soon after reset");
endmodule : send_port_properties

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [127:0] w; logic f, l, v, n;} beat_s;
    localparam int LIM = send_port_pkg::FIFO_DEPTH - send_port_pkg::READY_LATENCY - 2;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic app_valid = 1'b0, app_ready, app_first = 1'b0, app_last = 1'b0, app_void = 1'b0, app_null = 1'b0;
    logic [127:0] app_word = '0;
    logic [127:0] pkt_word;
    logic pkt_first, pkt_last, pkt_void, pkt_null, pkt_valid, fifo_empty, proto_err;
    logic pkt_ready = 1'b1;
    logic [11:0] cred_src [3];
    logic [11:0] cred_prev [3];
    logic [11:0] cc, cn, cp;
    logic [63:0] word_b;
    logic valid_b, void_b, err_b;
    logic ok_d1 = 1'b0, ok_d2 = 1'b0, mnul = 1'b0;
    int miscompares = 0, checked = 0, cyc = 0, lvl = 0, lvl_prev = 0, up = 0, thr = 4, i, len;
    integer seed = 32'ha3ac;
    beat_s exp_q[$];
    beat_s b;

    always #10 clk_i = ~clk_i;

    send_port_if link_if (.clk_i(clk_i), .rst_i(rst_i));
    send_port_if #(.DATA_W(64)) bad_if (.clk_i(clk_i), .rst_i(rst_i));
    send_port_src u_send_port_src (.link(link_if), .app_valid_i(app_valid), .app_ready_o(app_ready),
        .app_word_i(app_word), .app_first_i(app_first), .app_last_i(app_last), .app_void_i(app_void),
        .app_nullify_i(app_null));
    send_port_dev #(.DATA_W(128)) u_send_port_dev (.link(link_if), .pkt_word_o(pkt_word), .pkt_first_o(pkt_first),
        .pkt_last_o(pkt_last), .pkt_upper_void_o(pkt_void), .pkt_nullified_o(pkt_null), .pkt_valid_o(pkt_valid),
        .pkt_ready_i(pkt_ready), .cred_src_i(cred_src), .cred_cpl_data_o(cc), .cred_np_data_o(cn),
        .cred_post_data_o(cp), .fifo_empty_o(fifo_empty), .proto_err_o(proto_err));
    // Second device faces a hand-driven source that slips on purpose
    send_port_dev #(.DATA_W(64)) u_send_port_dev_b (.link(bad_if), .pkt_word_o(word_b), .pkt_first_o(),
        .pkt_last_o(), .pkt_upper_void_o(void_b), .pkt_nullified_o(), .pkt_valid_o(valid_b), .pkt_ready_i(1'b0),
        .cred_src_i(cred_src), .cred_cpl_data_o(), .cred_np_data_o(), .cred_post_data_o(), .fifo_empty_o(),
        .proto_err_o(err_b));
    send_port_properties u_send_port_properties (.clk_i(clk_i), .rst_i(rst_i),
        .send_beat_valid(link_if.send_beat_valid), .send_accept_ok(link_if.send_accept_ok),
        .send_first_beat(link_if.send_first_beat), .send_last_beat(link_if.send_last_beat),
        .send_upper_half_void(link_if.send_upper_half_void), .send_nullify_pulse(link_if.send_nullify_pulse));

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    // Leaves valid high so packets may follow back to back
    task automatic send_pkt(input int n, input bit nul, input bit vd);
        int t;
        for (int k = 0; k < n; k++) begin
            app_valid = 1'b1;
            app_word = {$random(seed), $random(seed), $random(seed), $random(seed)};
            app_first = (k == 0);
            app_last = (k == n - 1);
            app_void = vd && (k == n - 1);
            app_null = nul && (k == 1);
            t = 0;
            @(negedge clk_i);
            while (!app_ready && t < 300) begin
                t++;
                @(negedge clk_i);
            end
            if (t >= 300) check("app_ready_wait", 0, 1);
            @(posedge clk_i);
            #1;
        end
    endtask : send_pkt

    task automatic go_idle(input int n);
        app_valid = 1'b0;
        app_null = 1'b0;
        repeat (n) @(posedge clk_i);
        #1;
    endtask : go_idle

    task automatic drain_wait();
        thr = 4;
        for (int t = 0; t < 300 && !(exp_q.size() == 0 && fifo_empty === 1'b1); t++) @(negedge clk_i);
        @(posedge clk_i);
        #1;
        check("drained", exp_q.size() == 0, 1);
    endtask : drain_wait

    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 6000) begin
            miscompares++;
            close_out();
        end
    end

    always @(posedge clk_i) begin
        #1;
        pkt_ready = (($random(seed) & 3) < thr);
        for (int k = 0; k < 3; k++) cred_src[k] = $random(seed);
    end

    always @(negedge clk_i) begin
        if (rst_i) begin
            up = 0;
            lvl = 0;
            lvl_prev = 0;
            ok_d1 = 1'b0;
            ok_d2 = 1'b0;
            mnul = 1'b0;
            exp_q.delete();
            check("fifo_empty_rst", fifo_empty, 1);
            check("cred_rst", {cc, cn, cp}, 0);
        end else begin
            up++;
            if (up > 1) begin
                check("fifo_empty", fifo_empty, lvl == 0);
                check("cred_cpl", cc, cred_prev[0]);
                check("cred_np", cn, cred_prev[1]);
                check("cred_post", cp, cred_prev[2]);
                if (lvl > LIM && lvl_prev > LIM) check("ready_low", link_if.send_accept_ok, 0);
                if (lvl <= LIM && lvl_prev <= LIM) check("ready_high", link_if.send_accept_ok, 1);
            end
            lvl_prev = lvl;
            if (pkt_valid && pkt_ready) begin
                b = exp_q.size() > 0 ? exp_q.pop_front() : '{'x, 1'bx, 1'bx, 1'bx, 1'bx};
                check("pkt_word", pkt_word, b.w);
                check("pkt_flags", {pkt_first, pkt_last, pkt_void, pkt_null}, {b.f, b.l, b.v, b.n});
                lvl--;
            end
            if (app_valid && app_ready) begin
                mnul = mnul | app_null;
                b = '{app_word, app_first, app_last, app_void, app_last & mnul};
                if (app_last) mnul = 1'b0;
                exp_q.push_back(b);
            end
            if (link_if.send_beat_valid && ok_d2) lvl++;
            ok_d2 = ok_d1;
            ok_d1 = link_if.send_accept_ok;
        end
        cred_prev = cred_src;
    end

    initial begin
        for (int k = 0; k < 3; k++) cred_src[k] = '0;
        {bad_if.send_beat_valid, bad_if.send_first_beat, bad_if.send_last_beat} = 3'h0;
        {bad_if.send_upper_half_void, bad_if.send_nullify_pulse} = 2'h0;
        bad_if.send_beat_word = '0;
        repeat (4) @(posedge clk_i);
        #1 rst_i = 1'b0;
        for (i = 0; i < 8; i++) send_pkt(1 + i % 4, 0, i[0]);
        go_idle(2);
        // Nullified posted writes with payload, at least four beats
        for (i = 4; i < 7; i++) send_pkt(i, 1, 0);
        go_idle(1);
        thr = 0;
        fork
            send_pkt(14, 0, 1);
            begin
                repeat (40) @(posedge clk_i);
                thr = 1;
            end
        join
        go_idle(1);
        for (i = 0; i < 16; i++) begin
            len = 1 + $unsigned($random(seed)) % 6;
            send_pkt(len, len >= 4 && seed[0], seed[1]);
            if (i % 3 == 0) go_idle(1 + i % 2);
        end
        go_idle(1);
        drain_wait();
        check("proto_err", proto_err, 0);
        bad_if.send_beat_word = 64'h0123_4567_89ab_cdef;
        {bad_if.send_beat_valid, bad_if.send_first_beat, bad_if.send_last_beat} = 3'h7;
        bad_if.send_upper_half_void = 1'b1;
        @(posedge clk_i);
        #1;
        bad_if.send_beat_valid = 1'b0;
        bad_if.send_nullify_pulse = 1'b1;
        @(posedge clk_i);
        #1;
        bad_if.send_nullify_pulse = 1'b0;
        @(posedge clk_i);
        #1;
        check("narrow_beat", {valid_b, void_b, err_b}, 3'h5);
        check("narrow_word", word_b, 64'h0123_4567_89ab_cdef);
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1 rst_i = 1'b0;
        check("err_after_reset", {proto_err, err_b}, 0);
        send_pkt(5, 1, 1);
        go_idle(1);
        drain_wait();
        close_out();
    end
endmodule : testbench
